// ==== inc/pstx_pkg.sv ====
// Package of constants and types for the protocol select and transmit options block.
// -----------------------------------------------------------------------------
// Summary of operation
// -----------------------------------------------------------------------------
// Summary of operation
// RL1: Control bit 5 low picks reader mode; high picks peer-to-peer or card emulation.
// RL2: Peer-to-peer: bit 4 target/initiator, bit 3 passive/active.
// RL3: Protocol control resets to 0x02 on reset or enable low.
// RL4: Reader codes 00000-00011: 15693 single subcarrier, bit 1 rate, bit 0 coding.
// RL5: Reader codes 00100-00111: 15693 double subcarrier, bit 1 rate, bit 0 coding.
// RL6: Reader code 00010 is the default reader protocol.
// RL7: Reader codes 01000-01011: 14443 A, receive rate 106/212/424/848 kbps.
// RL8: Reader codes 01100-01111: 14443 B, receive rate 106/212/424/848 kbps.
// RL9: Codes 11010/11011 proprietary 212/424 kbps; all other codes reserved.
// RL10: 14443 A or B may transmit at a rate set outside the protocol code.
// RL11: Peer-to-peer bits 1:0 give 106, 212, 424 kbps; 00 invalid.
// RL12: Card emulation bits 1:0: 00 is 14443 A, 01 is 14443 B, others invalid.
// RL13: Transmit options bits 7:5 hold extra guard time, 0 to 7 etu.
// RL14: Transmit options bit 4 sets end-of-frame low phase to 11 or 10 etu.
// RL15: Transmit options bit 3 sets start-of-frame high phase to 3 or 2 etu.
// RL16: Transmit options bit 2 sets start-of-frame low phase to 11 or 10 etu.
// RL17: Transmit options bit 1 set adds guard after every byte, else not last.
// RL18: Transmit options bit 0 drives select acknowledge bit 6 under auto anticollision.
// RL19: Transmit options register clears to 0x00 on reset or enable low.
package pstx_pkg;

   // -------------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------------
   localparam logic [4:0] PSTX_ADDR_CTRL = 5'h01;
   localparam logic [4:0] PSTX_ADDR_TXOPT = 5'h02;
   localparam logic [7:0] PSTX_CTRL_RST = 8'h02;
   localparam logic [7:0] PSTX_TXOPT_RST = 8'h00;

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int PSTX_CTRL_NFC_BIT = 5;
   localparam int PSTX_CTRL_INIT_BIT = 4;
   localparam int PSTX_CTRL_ACT_BIT = 3;
   localparam int PSTX_CTRL_CE_BIT = 2;
   localparam int PSTX_TX_GUARD_HI = 7;
   localparam int PSTX_TX_GUARD_LO = 5;
   localparam int PSTX_TX_EOF_BIT = 4;
   localparam int PSTX_TX_SOFH_BIT = 3;
   localparam int PSTX_TX_SOFL_BIT = 2;
   localparam int PSTX_TX_EVERY_BIT = 1;
   localparam int PSTX_TX_L4_BIT = 0;
   localparam int PSTX_SAK_L4_BIT = 6;

   // -------------------------------------------------------------------------
   // Frame timing in etu
   // -------------------------------------------------------------------------
   localparam logic [3:0] PSTX_EOF_LOW_SHORT = 4'd10;
   localparam logic [3:0] PSTX_EOF_LOW_LONG = 4'd11;
   localparam logic [3:0] PSTX_SOF_HIGH_SHORT = 4'd2;
   localparam logic [3:0] PSTX_SOF_HIGH_LONG = 4'd3;
   localparam logic [3:0] PSTX_SOF_LOW_SHORT = 4'd10;
   localparam logic [3:0] PSTX_SOF_LOW_LONG = 4'd11;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      PSTX_MODE_READER = 2'd0,
      PSTX_MODE_PEER = 2'd1,
      PSTX_MODE_CARD = 2'd2
   } pstx_mode_t;

   typedef enum logic [2:0] {
      PSTX_PROT_NONE = 3'd0,
      PSTX_PROT_VICINITY = 3'd1,
      PSTX_PROT_PROX_A = 3'd2,
      PSTX_PROT_PROX_B = 3'd3,
      PSTX_PROT_PROPRIETARY = 3'd4,
      PSTX_PROT_PEER = 3'd5
   } pstx_proto_t;

   typedef enum logic [3:0] {
      PSTX_RATE_NONE = 4'd0,
      PSTX_RATE_6K62 = 4'd1,
      PSTX_RATE_26K48 = 4'd2,
      PSTX_RATE_6K67 = 4'd3,
      PSTX_RATE_26K69 = 4'd4,
      PSTX_RATE_106K = 4'd5,
      PSTX_RATE_212K = 4'd6,
      PSTX_RATE_424K = 4'd7,
      PSTX_RATE_848K = 4'd8
   } pstx_rate_t;

   typedef struct packed {
      pstx_mode_t mode;
      pstx_proto_t proto;
      pstx_rate_t rate;
      logic dualSubcarrier;
      logic coding256;
      logic initiator;
      logic activeMode;
      logic valid;
      logic txRateSplit;
   } pstx_cfg_t;

   typedef struct packed {
      logic [2:0] guardEtu;
      logic [3:0] endFrameLowLen;
      logic [3:0] startFrameHighLen;
      logic [3:0] startFrameLowLen;
      logic guardEveryByte;
      logic layer4ComplianceFlag;
   } pstx_txopt_t;

endpackage

// ==== hdl/pstx_decode.sv ====
// Combinational decode of the protocol control byte into mode, protocol and rate.
`timescale 1ns/1ps
module pstx_decode
   import pstx_pkg::*;
(
   input wire logic [7:0] ctrl,
   output pstx_cfg_t cfg
);

   logic [4:0] code;

   always_comb begin
      code = ctrl[4:0];
      cfg = '0;
      cfg.mode = PSTX_MODE_READER;
      cfg.proto = PSTX_PROT_NONE;
      cfg.rate = PSTX_RATE_NONE;
      if (!ctrl[PSTX_CTRL_NFC_BIT]) begin
         cfg.mode = PSTX_MODE_READER; // RL1
         if (code[4:3] == 2'b00) begin
            cfg.proto = PSTX_PROT_VICINITY; // RL4 RL5
            cfg.dualSubcarrier = code[2]; // RL5
            cfg.coding256 = code[0];
            cfg.valid = 1'b1;
            unique case ({code[2], code[1]})
               2'b00: cfg.rate = PSTX_RATE_6K62; // RL4
               2'b01: cfg.rate = PSTX_RATE_26K48; // RL6
               2'b10: cfg.rate = PSTX_RATE_6K67; // RL5
               2'b11: cfg.rate = PSTX_RATE_26K69;
            endcase
         end else if (code[4:3] == 2'b01) begin
            cfg.proto = code[2] ? PSTX_PROT_PROX_B : PSTX_PROT_PROX_A; // RL7 RL8
            cfg.rate = pstx_rate_t'(4'(PSTX_RATE_106K) + {2'b00, code[1:0]});
            cfg.valid = 1'b1;
            // Transmit rate may be split from the receive rate elsewhere.
            cfg.txRateSplit = 1'b1; // RL10
         end else if (code == 5'h1A || code == 5'h1B) begin
            cfg.proto = PSTX_PROT_PROPRIETARY; // RL9
            cfg.rate = code[0] ? PSTX_RATE_424K : PSTX_RATE_212K;
            cfg.valid = 1'b1;
         end
      end else if (!ctrl[PSTX_CTRL_CE_BIT]) begin
         cfg.mode = PSTX_MODE_PEER; // RL1
         cfg.proto = PSTX_PROT_PEER;
         cfg.initiator = ctrl[PSTX_CTRL_INIT_BIT]; // RL2
         cfg.activeMode = ctrl[PSTX_CTRL_ACT_BIT]; // RL2
         cfg.valid = (code[1:0] != 2'b00); // RL11
         unique case (code[1:0])
            2'b00: cfg.rate = PSTX_RATE_NONE;
            2'b01: cfg.rate = PSTX_RATE_106K;
            2'b10: cfg.rate = PSTX_RATE_212K;
            2'b11: cfg.rate = PSTX_RATE_424K;
         endcase
      end else begin
         cfg.mode = PSTX_MODE_CARD; // RL12
         cfg.valid = !code[1];
         cfg.rate = code[1] ? PSTX_RATE_NONE : PSTX_RATE_106K;
         if (!code[1]) begin
            cfg.proto = code[0] ? PSTX_PROT_PROX_B : PSTX_PROT_PROX_A; // RL12
         end
      end
   end

endmodule

// ==== hdl/pstx_regs.sv ====
// Protocol control and transmit options registers with their decoded outputs.
`timescale 1ns/1ps
module pstx_regs
   import pstx_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enablePin,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [4:0] regAddr,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic autoAnticoll,
   output pstx_cfg_t cfg,
   output pstx_txopt_t txOpt,
   output logic sakLayer4Bit
);

   // -------------------------------------------------------------------------
   // Enable pin synchroniser
   // -------------------------------------------------------------------------
   logic enMeta_q, enMeta_d;
   logic enSync_q, enSync_d;
   logic regClear;

   always_comb begin
      enMeta_d = enablePin;
      enSync_d = enMeta_q;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         enMeta_q <= 1'b0;
         enSync_q <= 1'b0;
      end else begin
         enMeta_q <= enMeta_d;
         enSync_q <= enSync_d;
      end
   end

   // Enable low acts like power-on reset, but only after two flops of delay.
   assign regClear = sys_rst || !enSync_q;

   // -------------------------------------------------------------------------
   // Register file
   // -------------------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] txo_q, txo_d;
   logic [7:0] rdata_q, rdata_d;

   always_comb begin
      ctrl_d = ctrl_q;
      txo_d = txo_q;
      rdata_d = rdata_q;
      if (regClear) begin
         ctrl_d = PSTX_CTRL_RST; // RL3 RL6
         txo_d = PSTX_TXOPT_RST; // RL19
         rdata_d = 8'h00;
      end else begin
         if (regWr && regAddr == PSTX_ADDR_CTRL) begin
            ctrl_d = regWdata;
         end
         if (regWr && regAddr == PSTX_ADDR_TXOPT) begin
            txo_d = regWdata;
         end
         if (regRd) begin
            unique case (regAddr)
               PSTX_ADDR_CTRL: rdata_d = ctrl_q;
               PSTX_ADDR_TXOPT: rdata_d = txo_q;
               default: rdata_d = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      ctrl_q <= ctrl_d;
      txo_q <= txo_d;
      rdata_q <= rdata_d;
   end

   assign regRdata = rdata_q;

   // -------------------------------------------------------------------------
   // Decode and output staging
   // -------------------------------------------------------------------------
   pstx_cfg_t cfgComb;
   pstx_cfg_t cfg_q, cfg_d;
   pstx_txopt_t txOpt_q, txOpt_d;
   logic sak_q, sak_d;

   pstx_decode uDecode (
      .ctrl(ctrl_q),
      .cfg(cfgComb)
   );

   always_comb begin
      cfg_d = cfgComb;
      txOpt_d.guardEtu = txo_q[PSTX_TX_GUARD_HI:PSTX_TX_GUARD_LO]; // RL13
      txOpt_d.endFrameLowLen = txo_q[PSTX_TX_EOF_BIT] ?
         PSTX_EOF_LOW_LONG : PSTX_EOF_LOW_SHORT; // RL14
      txOpt_d.startFrameHighLen = txo_q[PSTX_TX_SOFH_BIT] ?
         PSTX_SOF_HIGH_LONG : PSTX_SOF_HIGH_SHORT; // RL15
      txOpt_d.startFrameLowLen = txo_q[PSTX_TX_SOFL_BIT] ?
         PSTX_SOF_LOW_LONG : PSTX_SOF_LOW_SHORT; // RL16
      txOpt_d.guardEveryByte = txo_q[PSTX_TX_EVERY_BIT]; // RL17
      txOpt_d.layer4ComplianceFlag = txo_q[PSTX_TX_L4_BIT];
      // Outside auto anticollision the flag has no effect on the answer.
      sak_d = autoAnticoll && txo_q[PSTX_TX_L4_BIT]; // RL18
   end

   always_ff @(posedge clk) begin
      cfg_q <= cfg_d;
      txOpt_q <= txOpt_d;
      sak_q <= sak_d;
   end

   assign cfg = cfg_q;
   assign txOpt = txOpt_q;
   assign sakLayer4Bit = sak_q;

   // -------------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------------
   sequence sTxWrite;
      !regClear && regWr && regAddr == PSTX_ADDR_TXOPT;
   endsequence

   sequence sSettle;
      ##2 1'b1;
   endsequence

   AST_CTRL_RESET: assert property (@(posedge clk) regClear |=> ctrl_q == 8'h02) // RL3
      else $error("Protocol control not at reset value.");
   AST_TXO_RESET: assert property (@(posedge clk) regClear |=> txo_q == 8'h00) // RL19
      else $error("Transmit options not cleared.");
   AST_DEFAULT_RATE: assert property (@(posedge clk) disable iff (sys_rst)
      regClear ##1 !regWr |=> cfg.rate == PSTX_RATE_26K48 && !cfg.dualSubcarrier) // RL6
      else $error("Default reader protocol wrong.");
   AST_MODE: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> (cfg.mode == PSTX_MODE_READER) == !$past(ctrl_q[5])) // RL1
      else $error("Mode does not follow control bit 5.");
   AST_PEER_ROLE: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_q[5:2] == 4'b1110 |=> cfg.initiator && cfg.activeMode) // RL2
      else $error("Peer role bits not decoded.");
   AST_GUARD: assert property (@(posedge clk) disable iff (sys_rst)
      sTxWrite ##0 sSettle |-> txOpt.guardEtu == $past(regWdata[7:5], 2)) // RL13
      else $error("Guard time not taken from write.");
   AST_EOF: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> txOpt.endFrameLowLen == ($past(txo_q[4]) ? 4'd11 : 4'd10)) // RL14
      else $error("End of frame length wrong.");
   AST_SOF: assert property (@(posedge clk) disable iff (sys_rst)
      1'b1 |=> txOpt.startFrameHighLen == ($past(txo_q[3]) ? 4'd3 : 4'd2)
      && txOpt.startFrameLowLen == ($past(txo_q[2]) ? 4'd11 : 4'd10)) // RL15 RL16
      else $error("Start of frame lengths wrong.");
   AST_SAK: assert property (@(posedge clk) disable iff (sys_rst)
      !autoAnticoll |=> !sakLayer4Bit) // RL18
      else $error("Compliance bit driven without anticollision.");
   AST_PEER_INVALID: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_q[5] && !ctrl_q[2] && ctrl_q[1:0] == 2'b00 |=> !cfg.valid) // RL11
      else $error("Peer code 00 reported valid.");
   AST_CARD: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_q[5] && ctrl_q[2] && ctrl_q[1:0] == 2'b01 |=> cfg.proto == PSTX_PROT_PROX_B) // RL12
      else $error("Card emulation B not decoded.");
   AST_RESERVED: assert property (@(posedge clk) disable iff (sys_rst)
      !ctrl_q[5] && ctrl_q[4:0] == 5'h13 |=> !cfg.valid) // RL9
      else $error("Reserved code reported valid.");
   AST_PROX_RATE: assert property (@(posedge clk) disable iff (sys_rst)
      ctrl_q[5:0] == 6'h0F |=> cfg.rate == PSTX_RATE_848K && cfg.txRateSplit) // RL8 RL10
      else $error("Type B 848 kbps not decoded.");

endmodule

// ==== tb/pstx_regs_tb.sv ====
// Self-checking testbench for the protocol select and transmit options registers.
`timescale 1ns/1ps
module pstx_regs_tb
   import pstx_pkg::*;
;
   // ---------------------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------------------
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic enablePin = 1'b1;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [4:0] regAddr = 5'h00;
   logic [7:0] regWdata = 8'h00;
   logic autoAnticoll = 1'b0;
   logic [7:0] regRdata;
   pstx_cfg_t cfg;
   pstx_txopt_t txOpt;
   logic sakLayer4Bit;
   logic chkStb = 1'b0;
   logic rdSeen = 1'b0;
   int err_count = 0;
   int tests_run = 0;
   int seed = 32'h886f;
   logic [7:0] curCtrl;
   logic [7:0] curTx;
   logic [7:0] readQ[$];
   logic [14:0] cfgQ[$];
   logic [17:0] txQ[$];

   always #20 clk = ~clk;

   pstx_regs DUT (
      .clk(clk),
      .sys_rst(sys_rst),
      .enablePin(enablePin),
      .regWr(regWr),
      .regRd(regRd),
      .regAddr(regAddr),
      .regWdata(regWdata),
      .regRdata(regRdata),
      .autoAnticoll(autoAnticoll),
      .cfg(cfg),
      .txOpt(txOpt),
      .sakLayer4Bit(sakLayer4Bit)
   );

   // ---------------------------------------------------------------------------
   // Expected values
   // ---------------------------------------------------------------------------
   function automatic pstx_cfg_t exp_cfg(input logic [7:0] c);
      pstx_cfg_t e;
      e = '0;
      if (c[5]) begin
         if (c[2]) begin
            e.mode = PSTX_MODE_CARD;
            e.valid = ~c[1];
            e.proto = c[0] ? PSTX_PROT_PROX_B : PSTX_PROT_PROX_A;
            e.rate = PSTX_RATE_106K;
         end else begin
            e.mode = PSTX_MODE_PEER;
            e.proto = PSTX_PROT_PEER;
            e.initiator = c[4];
            e.activeMode = c[3];
            e.valid = (c[1:0] != 2'b00);
            e.rate = pstx_rate_t'(PSTX_RATE_106K + c[1:0] - 4'd1);
         end
      end else if (c[4:3] == 2'b00) begin
         e.proto = PSTX_PROT_VICINITY;
         e.valid = 1'b1;
         e.dualSubcarrier = c[2];
         e.coding256 = c[0];
         e.rate = c[2] ? (c[1] ? PSTX_RATE_26K69 : PSTX_RATE_6K67)
                       : (c[1] ? PSTX_RATE_26K48 : PSTX_RATE_6K62);
      end else if (c[4:3] == 2'b01) begin
         e.proto = c[2] ? PSTX_PROT_PROX_B : PSTX_PROT_PROX_A;
         e.valid = 1'b1;
         e.txRateSplit = 1'b1;
         e.rate = pstx_rate_t'(PSTX_RATE_106K + c[1:0]);
      end else if (c[4:1] == 4'b1101) begin
         e.proto = PSTX_PROT_PROPRIETARY;
         e.valid = 1'b1;
         e.rate = c[0] ? PSTX_RATE_424K : PSTX_RATE_212K;
      end
      return e;
   endfunction

   // Fields that no setting defines are masked so only documented behaviour is judged.
   function automatic logic [14:0] cfg_key(input pstx_cfg_t c);
      logic vic;
      logic peer;
      vic = (c.proto == PSTX_PROT_VICINITY);
      peer = (c.mode == PSTX_MODE_PEER);
      if (c.valid !== 1'b1) begin
         return {c.mode, 13'h0000};
      end
      return {c.mode, c.proto, c.rate, 1'b1, c.txRateSplit,
              vic ? {c.dualSubcarrier, c.coding256} : 2'b00,
              peer ? {c.initiator, c.activeMode} : 2'b00};
   endfunction

   function automatic logic [17:0] exp_txo(input logic [7:0] v, input logic aa);
      pstx_txopt_t e;
      e.guardEtu = v[7:5];
      e.endFrameLowLen = v[4] ? PSTX_EOF_LOW_LONG : PSTX_EOF_LOW_SHORT;
      e.startFrameHighLen = v[3] ? PSTX_SOF_HIGH_LONG : PSTX_SOF_HIGH_SHORT;
      e.startFrameLowLen = v[2] ? PSTX_SOF_LOW_LONG : PSTX_SOF_LOW_SHORT;
      e.guardEveryByte = v[1];
      e.layer4ComplianceFlag = v[0];
      return {e, aa & v[0]};
   endfunction

   // ---------------------------------------------------------------------------
   // Compare tasks and monitor
   // ---------------------------------------------------------------------------
   task automatic report(input logic [31:0] act, input logic [31:0] exp, input logic ok);
      tests_run++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, act, exp);
      end
   endtask

   task automatic cmp_byte(input logic [7:0] act, input logic [7:0] exp);
      report({24'h0000_00, act}, {24'h0000_00, exp}, act === exp);
   endtask

   task automatic cmp_cfg(input logic [14:0] act, input logic [14:0] exp);
      report({17'h0_0000, act}, {17'h0_0000, exp}, act === exp);
   endtask

   task automatic cmp_txo(input logic [17:0] act, input logic [17:0] exp);
      report({14'h0000, act}, {14'h0000, exp}, act === exp);
   endtask

   always @(posedge clk) rdSeen <= regRd;

   // An empty queue pops an unknown, so a surplus result is still counted as wrong.
   always @(negedge clk) begin
      if (rdSeen === 1'b1) begin
         cmp_byte(regRdata, readQ.pop_front());
      end
      if (chkStb === 1'b1) begin
         cmp_cfg(cfg_key(cfg), cfgQ.pop_front());
         cmp_txo({txOpt, sakLayer4Bit}, txQ.pop_front());
      end
   end

   // ---------------------------------------------------------------------------
   // Driver tasks
   // ---------------------------------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      regWr = 1'b1;
      regAddr = a;
      regWdata = d;
      tick(1);
      regWr = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      readQ.push_back(exp);
      regRd = 1'b1;
      regAddr = a;
      tick(1);
      regRd = 1'b0;
   endtask

   task automatic chk();
      tick(3);
      cfgQ.push_back(cfg_key(exp_cfg(curCtrl)));
      txQ.push_back(exp_txo(curTx, autoAnticoll));
      chkStb = 1'b1;
      tick(1);
      chkStb = 1'b0;
   endtask

   task automatic close_out();
      if (readQ.size() != 0 || cfgQ.size() != 0 || txQ.size() != 0) begin
         err_count++;
      end
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      tick(100000);
      err_count++;
      close_out();
   end

   // ---------------------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------------------
   initial begin
      curCtrl = PSTX_CTRL_RST;
      curTx = PSTX_TXOPT_RST;
      tick(16);
      sys_rst = 1'b0;
      tick(4);
      rd(PSTX_ADDR_CTRL, 8'h02);
      rd(PSTX_ADDR_TXOPT, 8'h00);
      rd(5'h03, 8'h00);
      chk();
      for (int i = 0; i < 256; i++) begin
         curCtrl = i[7:0];
         wr(PSTX_ADDR_CTRL, curCtrl);
         rd(PSTX_ADDR_CTRL, curCtrl);
         chk();
      end
      for (int i = 0; i < 40; i++) begin
         curTx = $random(seed);
         autoAnticoll = $random(seed);
         wr(PSTX_ADDR_TXOPT, curTx);
         rd(PSTX_ADDR_TXOPT, curTx);
         chk();
      end
      wr(5'h03, 8'h55);
      rd(PSTX_ADDR_CTRL, curCtrl);
      rd(PSTX_ADDR_TXOPT, curTx);
      rd(5'h03, 8'h00);
      // A read in the cycle of a write returns the value from before it.
      readQ.push_back(curTx);
      regWr = 1'b1;
      regRd = 1'b1;
      regAddr = PSTX_ADDR_TXOPT;
      regWdata = 8'hA5;
      tick(1);
      regWr = 1'b0;
      regRd = 1'b0;
      curTx = 8'hA5;
      rd(PSTX_ADDR_TXOPT, curTx);
      enablePin = 1'b0;
      tick(3);
      wr(PSTX_ADDR_CTRL, 8'h2C);
      tick(3);
      enablePin = 1'b1;
      tick(5);
      curCtrl = PSTX_CTRL_RST;
      curTx = PSTX_TXOPT_RST;
      rd(PSTX_ADDR_CTRL, curCtrl);
      rd(PSTX_ADDR_TXOPT, curTx);
      chk();
      wr(PSTX_ADDR_CTRL, 8'h0B);
      wr(PSTX_ADDR_TXOPT, 8'h5F);
      sys_rst = 1'b1;
      tick(2);
      sys_rst = 1'b0;
      tick(4);
      rd(PSTX_ADDR_CTRL, curCtrl);
      rd(PSTX_ADDR_TXOPT, curTx);
      chk();
      tick(3);
      close_out();
   end
endmodule
